//--- rtl/ppi_port.sv
`timescale 1ns/10ps
`default_nettype none
module ppi_port #(
	parameter bit STOP_PORT = 1'b1
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Power mode and stop request
	input wire logic [1:0] pwr_mode_i,
	input wire logic stop_i,
	input wire logic [7:0] dsleep_pin_i,
	// Pins
	input wire logic [7:0] pin_in_i,
	input wire logic [7:0] pin_out_i,
	input wire logic [7:0] pin_oe_i,
	output logic [7:0] pin_out_o,
	output logic [7:0] pin_oe_o,
	output logic [7:0] in_buf_en_o,
	output logic [7:0] swd_en_o,
	// Interrupt routes
	output logic irq_fixed_o,
	output logic irq_fabric_o,
	output logic [7:0] raw_fabric_o,
	output logic wake_o
);
	logic [31:0] cfg, next_cfg;
	logic [7:0] ctrl, next_ctrl;
	logic [8:0] flag, next_flag;
	logic [31:0] dat, next_dat;
	logic ack, next_ack;
	logic [7:0] sync1, sync2, pin_prev;
	logic [7:0] out_q, next_out, oe_q, next_oe, ibuf, next_ibuf;
	logic [7:0] raw_q, next_raw;
	localparam int FLT_LEN_W = 1;
	logic flt_lvl, next_flt_lvl, flt_prev;
	logic [FLT_LEN_W:0] flt_cnt, next_flt_cnt;
	logic irq_f, irq_b, wake, next_wake;
	logic [7:0] lvl, rise, fall;
	logic [8:0] hit;
	logic flt_in, flt_sample_prev;
	logic wr;

	// Pin level, optionally through two-stage synchronizer
	// sync select
	always_ff @(posedge clk_i)
	begin
		sync1 <= pin_in_i;
		sync2 <= sync1;
	end
	assign lvl = (ctrl[ppi_pkg::CTRL_SYNC_POS] ? sync2 : pin_in_i) & ibuf;

	// Per-pin edge detectors
	// edge select decode
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_edge
			assign rise[i] = lvl[i] & ~pin_prev[i];
			assign fall[i] = ~lvl[i] & pin_prev[i];
			assign hit[i] = (cfg[2*i+1 -: 2] == ppi_pkg::EDGE_RISE && rise[i])
				|| (cfg[2*i+1 -: 2] == ppi_pkg::EDGE_FALL && fall[i])
				|| (cfg[2*i+1 -: 2] == ppi_pkg::EDGE_BOTH
					&& (rise[i] | fall[i]));
		end
	endgenerate

	assign flt_in = lvl[cfg[ppi_pkg::CFG_FLT_POS+2:ppi_pkg::CFG_FLT_POS]];
	// Filter edge select sits above the pin index field, no overlap
	assign hit[8] = (cfg[ppi_pkg::CFG_FLT_EDGE_POS +: 2] == ppi_pkg::EDGE_RISE
			&& flt_lvl && !flt_prev)
		|| (cfg[ppi_pkg::CFG_FLT_EDGE_POS +: 2] == ppi_pkg::EDGE_FALL
			&& !flt_lvl && flt_prev)
		|| (cfg[ppi_pkg::CFG_FLT_EDGE_POS +: 2] == ppi_pkg::EDGE_BOTH
			&& (flt_lvl != flt_prev));

	assign wr = cyc_i && stb_i && we_i && !ack;
	// Raw pin levels for the raw route, registered below
	assign next_raw = lvl & {8{ctrl[3:2] == 2'(ppi_pkg::PPI_RAW)}};

	// Glitch filter: level changes after stable input for FLT_LEN samples
	always_comb
	begin
		next_flt_lvl = flt_lvl;
		next_flt_cnt = flt_cnt;
		if (flt_in == flt_lvl)
			next_flt_cnt = '0;
		else if (flt_cnt == (FLT_LEN_W+1)'(ppi_pkg::FLT_LEN - 1))
		begin
			next_flt_lvl = flt_in;
			next_flt_cnt = '0;
		end
		else
			next_flt_cnt = flt_cnt + 1'b1;
	end

	// Flags, set wins over write-one clear
	always_comb
	begin
		next_flag = flag;
		if (wr && adr_i == ppi_pkg::ADDR_STATUS)
		begin
			if (sel_i[0])
				next_flag[7:0] = flag[7:0] & ~dat_i[7:0];
			if (sel_i[1])
				next_flag[8] = flag[8] & ~dat_i[8];
		end
		next_flag = next_flag | hit;
	end

	// Register writes and read mux
	always_comb
	begin
		next_cfg = cfg;
		next_ctrl = ctrl;
		next_ack = cyc_i && stb_i && !ack;
		next_dat = dat;
		if (wr && adr_i == ppi_pkg::ADDR_CFG)
		begin
			for (int b = 0; b < 4; b++)
				if (sel_i[b])
					next_cfg[8*b +: 8] = dat_i[8*b +: 8];
		end
		if (wr && adr_i == ppi_pkg::ADDR_CTRL && sel_i[0])
		begin
			next_ctrl = dat_i[7:0];
			// debug lines kept until boot flag set
			if (!ctrl[ppi_pkg::CTRL_BOOT_POS])
				next_ctrl[ppi_pkg::CTRL_SWD_POS] = 1'b1;
		end
		if (cyc_i && stb_i && !we_i && !ack)
		begin
			unique case (adr_i)
				ppi_pkg::ADDR_CFG: next_dat = cfg;
				// flags and levels in one word
				ppi_pkg::ADDR_STATUS: next_dat = {7'h00, flt_lvl, lvl,
					7'h00, flag};
				ppi_pkg::ADDR_CTRL: next_dat = {24'h000000, ctrl};
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	// Pin freeze, input buffers and wake
	always_comb
	begin
		next_out = pin_out_i;
		next_oe = pin_oe_i;
		next_ibuf = 8'hFF;
		next_wake = |flag;
		unique case (ppi_pkg::ppi_pwr_t'(pwr_mode_i))
			ppi_pkg::PPI_ACTIVE, ppi_pkg::PPI_SLEEP: ;
			ppi_pkg::PPI_DEEP:
			begin
				next_out = (pin_out_i & dsleep_pin_i) | (out_q & ~dsleep_pin_i);
				next_oe = (pin_oe_i & dsleep_pin_i) | (oe_q & ~dsleep_pin_i);
			end
			ppi_pkg::PPI_HIB:
			begin
				next_out = out_q;
				next_oe = oe_q;
			end
		endcase
		if (stop_i)
		begin
			next_ibuf = STOP_PORT ? 8'h01 << ppi_pkg::STOP_WAKE_PIN : 8'h00;
			next_wake = STOP_PORT && flag[ppi_pkg::STOP_WAKE_PIN];
			next_out = out_q;
			next_oe = oe_q;
		end
	end

	// All state registers except the synchronizer stages
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg <= ppi_pkg::CFG_RESET;
			ctrl <= ppi_pkg::CTRL_RESET;
			flag <= '0;
			dat <= '0;
			ack <= 1'b0;
			pin_prev <= '0;
			out_q <= '0;
			oe_q <= '0;
			ibuf <= '0;
			flt_lvl <= 1'b0;
			flt_prev <= 1'b0;
			flt_cnt <= '0;
			wake <= 1'b0;
			irq_f <= 1'b0;
			irq_b <= 1'b0;
			raw_q <= '0;
		end
		else
		begin
			cfg <= next_cfg;
			ctrl <= next_ctrl;
			flag <= next_flag;
			dat <= next_dat;
			ack <= next_ack;
			pin_prev <= lvl;
			out_q <= next_out;
			oe_q <= next_oe;
			// Buffers enable once software has configured the port
			ibuf <= (cfg != ppi_pkg::CFG_RESET || ctrl[ppi_pkg::CTRL_BOOT_POS])
				? next_ibuf : 8'h00;
			flt_lvl <= next_flt_lvl;
			flt_prev <= flt_lvl;
			flt_cnt <= next_flt_cnt;
			wake <= next_wake;
			// OR of flags to one request
			// level stays while any flag set
			irq_f <= (|next_flag) && ctrl[3:2] == 2'(ppi_pkg::PPI_FIXED);
			irq_b <= (|next_flag) && ctrl[3:2] == 2'(ppi_pkg::PPI_FABRIC);
			raw_q <= next_raw;
		end
	end

	assign dat_o = dat;
	assign ack_o = ack;
	assign pin_out_o = out_q;
	assign pin_oe_o = oe_q;
	assign in_buf_en_o = ibuf;
	assign swd_en_o = {8{ctrl[ppi_pkg::CTRL_SWD_POS]}};
	assign irq_fixed_o = irq_f;
	assign irq_fabric_o = irq_b;
	assign raw_fabric_o = raw_q;
	assign wake_o = wake;

	a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == ppi_pkg::ADDR_STATUS && sel_i[0] && dat_i[0] && !hit[0]
		|=> !flag[0]) else $error("flag not cleared");
	a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		hit[0] |=> flag[0]) else $error("flag not set");
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(|flag) && ctrl[3:2] == 2'h0 |-> irq_f) else $error("irq low");
	a_edge_off: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg[1:0] == ppi_pkg::EDGE_OFF |-> !hit[0]) else $error("edge off");
	a_hib_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_mode_i == 2'h3 && !stop_i |=> $stable(out_q)) else $error("hib");
	a_stop_buf: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_i ##1 stop_i |-> (ibuf & 8'hFB) == 8'h00) else $error("stop");
	a_irq_none: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(flag) == 9'h000 && !$past(|hit) |-> !irq_f && !irq_b)
		else $error("spurious irq");
	a_swd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl[ppi_pkg::CTRL_BOOT_POS] |-> ctrl[ppi_pkg::CTRL_SWD_POS])
		else $error("swd lost");

	a_rise_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg[3:2] == ppi_pkg::EDGE_RISE && lvl[1] && !pin_prev[1]
		|=> flag[1]) else $error("rise missed");

	a_fall_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg[5:4] == ppi_pkg::EDGE_FALL && !lvl[2] && pin_prev[2]
		|=> flag[2]) else $error("fall missed");

	a_both_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg[7:6] == ppi_pkg::EDGE_BOTH && lvl[3] != pin_prev[3]
		|=> flag[3]) else $error("both missed");

	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		flag[0] && !(wr && adr_i == ppi_pkg::ADDR_STATUS && sel_i[0]
		&& dat_i[0]) |=> flag[0]) else $error("flag dropped");

	a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == ppi_pkg::ADDR_STATUS && dat_i[8:0] == 9'h000
		|=> (flag & $past(flag)) == $past(flag)) else $error("zero cleared");

	a_flt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		hit[8] |=> flag[8]) else $error("filter flag");

	a_flt_settle: assert property (@(posedge clk_i) disable iff (rst_i)
		flt_in != flt_lvl
		&& flt_cnt == (FLT_LEN_W+1)'(ppi_pkg::FLT_LEN - 1)
		|=> flt_lvl == $past(flt_in)) else $error("filter stuck");

	// any new flag raises fixed irq while the fixed route is selected
	a_irq_or: assert property (@(posedge clk_i) disable iff (rst_i)
		(|next_flag) && ctrl[3:2] == 2'h0 |=> irq_f)
		else $error("fixed irq low");

	a_fabric_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		(|next_flag) && ctrl[3:2] == 2'h1 |=> irq_b && !irq_f)
		else $error("fabric irq");

	a_raw_route: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl[3:2] == 2'h2 |=> raw_q == $past(lvl))
		else $error("raw route");

	a_deep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_mode_i == 2'h2 && !stop_i
		|=> ((out_q ^ $past(out_q)) & ~$past(dsleep_pin_i)) == 8'h00)
		else $error("deep sleep drift");

	a_sleep_live: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_mode_i == 2'h1 && !stop_i |=> out_q == $past(pin_out_i))
		else $error("sleep frozen");

	a_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_i |=> $stable(out_q) && $stable(oe_q))
		else $error("stop drift");

	// stop wakes only on the wake pin
	a_wake_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_i |=> wake == (STOP_PORT && $past(flag[ppi_pkg::STOP_WAKE_PIN])))
		else $error("stop wake");

	a_reset_off: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> ibuf == 8'h00 && oe_q == 8'h00)
		else $error("pins on at reset");

	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack |=> !ack) else $error("ack held");
endmodule : ppi_port
`default_nettype wire

//--- rtl/ppi_pkg.sv
package ppi_pkg;
	// Register byte offsets on the Wishbone bus
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h8;
	// Configuration field layout
	localparam int CFG_FLT_POS = 16;
	localparam int CFG_FLT_EDGE_POS = 19;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// Control register fields
	localparam int CTRL_MODE_POS = 0;
	localparam int CTRL_ROUTE_POS = 2;
	localparam int CTRL_SYNC_POS = 4;
	localparam int CTRL_SWD_POS = 5;
	localparam int CTRL_BOOT_POS = 6;
	localparam logic [7:0] CTRL_RESET = 8'h30;
	// Status field positions
	localparam int ST_FLT_FLAG = 8;
	localparam int ST_PIN_POS = 16;
	localparam int ST_FLT_LVL = 24;
	// Edge select encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Glitch filter length in samples
	localparam int FLT_LEN = 2;
	// Wake pin index for stop mode
	localparam int STOP_WAKE_PIN = 2;
	// Power modes
	typedef enum logic [1:0] {PPI_ACTIVE, PPI_SLEEP, PPI_DEEP, PPI_HIB} ppi_pwr_t;
	// Interrupt routes
	typedef enum logic [1:0] {PPI_FIXED, PPI_FABRIC, PPI_RAW} ppi_route_t;
endpackage : ppi_pkg

//--- sim/ppi_isrc.sv
`timescale 1ns/10ps
`default_nettype none
module ppi_isrc (
	// Clock, reset and trigger mode
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	// Port interrupt in, count out
	input wire logic irq_i,
	output logic [15:0] cnt_o
);
	logic prev;
	logic [15:0] next_cnt;
	always_comb
	begin
		next_cnt = cnt_o;
		if (irq_i && (level_i || !prev))
			next_cnt = cnt_o + 16'h0001;
	end
	// Registers the count and last request level
	always_ff @(posedge clk_i)
	begin
		prev <= rst_i ? 1'b0 : irq_i;
		cnt_o <= rst_i ? 16'h0000 : next_cnt;
	end
endmodule : ppi_isrc
`default_nettype wire

//--- sim/ppi_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
$display("BAD %0t got %h want %h", $time, a, b); end end
module ppi_port_bench;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic stp = 1'b0, ack, irqf, irqb, wake;
	logic [3:0] adr = 4'h0;
	logic [31:0] dw = 32'h0, dr;
	logic [1:0] pwr = 2'h0;
	logic [7:0] dsl = 8'h00, pin = 8'h00, po = 8'h00, oe = 8'h00;
	logic [7:0] pout, poe, ibuf, swd, raw;
	logic [15:0] cnt;
	logic [31:0] expq[$];
	logic [31:0] exp_v;
	int error_cnt = 0, checked = 0, seed = 69;
	// Free-running system clock
	always #10 clk = ~clk;
	ppi_port uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dw), .dat_o(dr),
		.ack_o(ack), .pwr_mode_i(pwr), .stop_i(stp), .dsleep_pin_i(dsl),
		.pin_in_i(pin), .pin_out_i(po), .pin_oe_i(oe), .pin_out_o(pout),
		.pin_oe_o(poe), .in_buf_en_o(ibuf), .swd_en_o(swd),
		.irq_fixed_o(irqf), .irq_fabric_o(irqb), .raw_fabric_o(raw),
		.wake_o(wake));
	ppi_isrc isrc (.clk_i(clk), .rst_i(rst), .level_i(1'b0),
		.irq_i(irqf), .cnt_o(cnt));
	// Compares read data with the oldest note
	always @(posedge clk)
		if (ack && !we && expq.size() > 0)
		begin
			exp_v = expq.pop_front();
			`CHK(dr, exp_v)
		end
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		if (!w)
			expq.push_back(d);
		@(posedge clk);
		{cyc, stb, we, adr, dw} <= {2'b11, w, a, w ? d : 32'h0};
		do @(posedge clk); while (!ack && ++n < 50);
		if (n >= 50)
		begin
			error_cnt++;
			complete_run();
		end
		{cyc, stb, we} <= 3'b000;
		@(posedge clk);
	endtask : bus
	task automatic pins(input logic [7:0] v);
		@(posedge clk);
		pin <= v;
		repeat (6) @(posedge clk);
	endtask : pins
	function automatic logic [31:0] st(logic [7:0] fl, logic [7:0] lv);
		return {7'h00, lv[0], lv, 8'h00, fl};
	endfunction : st
	task complete_run;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// Cuts a hang short
	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		logic [7:0] r, f;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(swd, 8'hFF)
		`CHK(ibuf, 8'h00)
		bus(0, ppi_pkg::ADDR_CFG, ppi_pkg::CFG_RESET);
		bus(0, ppi_pkg::ADDR_CTRL, {24'h0, ppi_pkg::CTRL_RESET});
		bus(0, 4'hC, 32'h0);
		$display("test reset done");
		bus(1, ppi_pkg::ADDR_CTRL, 32'h50);
		for (int i = 0; i < 4; i++)
		begin
			r = 8'($random(seed));
			pins(r);
			bus(0, ppi_pkg::ADDR_STATUS, st(8'h00, r));
		end
		$display("test levels done");
		for (int m = 1; m < 4; m++)
		begin
			f = m[0] ? 8'hFF : 8'h00;
			@(posedge clk);
			pwr <= m[1:0];
			pins(8'h00);
			@(negedge clk);
			`CHK(ibuf, 8'hFF)
			bus(1, ppi_pkg::ADDR_CFG, {16'h0, {8{m[1:0]}}});
			bus(1, ppi_pkg::ADDR_STATUS, 32'h1FF);
			pins(8'hFF);
			bus(0, ppi_pkg::ADDR_STATUS, st(f, 8'hFF));
			@(negedge clk);
			`CHK(irqf, m[0])
			bus(1, ppi_pkg::ADDR_STATUS, 32'h0);
			bus(1, ppi_pkg::ADDR_STATUS, 32'h0F);
			bus(0, ppi_pkg::ADDR_STATUS, st(f & 8'hF0, 8'hFF));
			pins(8'h00);
			f = (f & 8'hF0) | (m[1] ? 8'hFF : 8'h00);
			bus(0, ppi_pkg::ADDR_STATUS, st(f, 8'h00));
			bus(1, ppi_pkg::ADDR_STATUS, 32'hFF);
			bus(0, ppi_pkg::ADDR_STATUS, st(8'h00, 8'h00));
			@(negedge clk);
			`CHK(irqf, 1'b0)
		end
		`CHK(cnt, 16'h0003)
		$display("test edges done");
		bus(1, ppi_pkg::ADDR_CTRL, 32'h54);
		bus(1, ppi_pkg::ADDR_CFG, {30'h0, ppi_pkg::EDGE_RISE});
		pins(8'h01);
		@(negedge clk);
		`CHK(irqb, 1'b1)
		`CHK(irqf, 1'b0)
		`CHK(wake, 1'b1)
		bus(1, ppi_pkg::ADDR_STATUS, 32'hFF);
		bus(1, ppi_pkg::ADDR_CTRL, 32'h58);
		@(negedge clk);
		`CHK(irqb, 1'b0)
		`CHK(raw, 8'h01)
		bus(1, ppi_pkg::ADDR_CTRL, 32'h50);
		pins(8'h00);
		$display("test routes done");
		@(posedge clk);
		{pwr, po, oe, dsl} <= {2'h0, 8'hA5, 8'hFF, 8'h0F};
		repeat (4) @(posedge clk);
		pwr <= 2'h2;
		repeat (3) @(posedge clk);
		po <= 8'h5A;
		repeat (4) @(negedge clk);
		`CHK(pout, 8'hAA)
		`CHK(poe, 8'hFF)
		@(posedge clk);
		pwr <= 2'h3;
		repeat (3) @(posedge clk);
		po <= 8'hFF;
		repeat (4) @(negedge clk);
		`CHK(pout, 8'hAA)
		@(posedge clk);
		{pwr, stp} <= {2'h0, 1'b1};
		repeat (4) @(negedge clk);
		`CHK(ibuf, 8'h04)
		$display("test power done");
		complete_run();
	end
endmodule : ppi_port_bench
`default_nettype wire
